/* hdl/dfgr_controller.sv */
`timescale 1ns/1ps
// Memory controller end: paces refreshes and tracks counting constraints
module dfgr_controller
#(
   parameter int REFI1_CYC = dfgr_pkg::REFI1_CYC
)
(
   input  wire logic          ref_clk,
   input  wire logic          arst_n,
   dfgr_if.controller         bus,
   input  wire logic [2:0]    req_mode,
   input  wire logic          req_mode_valid,
   input  wire logic          req_high_rate,
   input  wire logic          temperature_controlled_refresh,
   input  wire logic          req_sr_enter,
   input  wire logic          req_sr_exit,
   output logic               mode_accepted,
   output logic               mode_refused,
   output logic [1:0]         group_count,
   output logic               ctrl_idle
);
   typedef struct packed {
      dfgr_pkg::dfgr_host_e           st;
      logic [2:0]                     mode;
      logic [2:0]                     pend;
      logic [dfgr_pkg::CNT_W-1:0]     refi;
      logic [dfgr_pkg::CNT_W-1:0]     wait_c;
      logic [1:0]                     grp;
      logic [2:0]                     extra;
      logic                           acc;
      logic                           ref_c;
      logic                           hi;
      logic                           mrs;
      logic                           sre;
      logic                           srx;
      logic                           rfs;
   } dfgr_host_s;

   dfgr_host_s q;
   dfgr_host_s next_q;
   logic       mode_fast;
   logic       mode_quad;
   logic [dfgr_pkg::CNT_W-1:0] interval;
   logic       group_whole;
   logic       use_hi;

   assign mode_fast = (q.mode == dfgr_pkg::GRAN_FIXED_2X)
                      || (q.mode == dfgr_pkg::GRAN_OTF_1X2X);
   assign mode_quad = (q.mode == dfgr_pkg::GRAN_FIXED_4X)
                      || (q.mode == dfgr_pkg::GRAN_OTF_1X4X);
   // Higher rate only in fixed 2x/4x, or ON_THE_FLY_GRANULARITY on request
   assign use_hi = (q.mode == dfgr_pkg::GRAN_FIXED_2X)
                   || (q.mode == dfgr_pkg::GRAN_FIXED_4X)
                   || (q.mode[2] && req_high_rate);            // see (RULE6)
   // A forced higher-rate refresh keeps its own, shorter interval
   assign interval = (!use_hi && group_whole) ? dfgr_pkg::CNT_W'(REFI1_CYC) :
                     mode_quad ? dfgr_pkg::CNT_W'(REFI1_CYC / 4) :
                     dfgr_pkg::CNT_W'(REFI1_CYC / 2);         // see (RULE3) (RULE4)
   assign group_whole = mode_quad ? (q.grp == 2'h0) : !q.grp[0];

   always_comb
   begin
      next_q = q;
      next_q.ref_c = 1'b0;
      next_q.mrs = 1'b0;
      next_q.sre = 1'b0;
      next_q.srx = 1'b0;
      next_q.acc = 1'b0;
      // Refusal is a level while a forbidden request is held
      next_q.rfs = req_mode_valid && temperature_controlled_refresh
                   && req_mode != dfgr_pkg::GRAN_FIXED_1X;    // see (RULE15)
      if (q.refi != '0)
         next_q.refi = q.refi - 1'b1;
      unique case (q.st)
         dfgr_pkg::DFGR_HOST_IDLE:
         begin
            // Held or refused requests fall through so refresh never stalls
            if (req_mode_valid && group_whole       // see (RULE10) (RULE12)
                && !(temperature_controlled_refresh
                     && req_mode != dfgr_pkg::GRAN_FIXED_1X)) // see (RULE15)
            begin
               next_q.pend = req_mode;
               next_q.st = dfgr_pkg::DFGR_HOST_MODE;         // see (RULE21)
            end
            else if (req_sr_enter)
            begin
               next_q.sre = 1'b1;
               next_q.st = dfgr_pkg::DFGR_HOST_SELF;
            end
            else if (q.refi == '0)
            begin
               next_q.ref_c = 1'b1;
               next_q.hi = use_hi;
               // 1x only after a whole group of higher-rate refreshes
               if (use_hi || group_whole)                     // see (RULE11) (RULE13)
               begin
                  next_q.grp = use_hi ? q.grp + 2'h1 : 2'h0;  // see (RULE22)
                  if (!use_hi || mode_quad)
                     next_q.grp = use_hi ? q.grp + 2'h1 : 2'h0;
                  else
                     next_q.grp = {1'b0, ~q.grp[0]};
               end
               else
               begin
                  next_q.hi = 1'b1;
                  next_q.grp = mode_quad ? q.grp + 2'h1
                                         : {1'b0, ~q.grp[0]};
               end
               next_q.refi = interval;                        // see (RULE9)
               next_q.wait_c = (next_q.hi && mode_quad)
                  ? dfgr_pkg::CNT_W'(dfgr_pkg::RFC4_CYC)
                  : next_q.hi ? dfgr_pkg::CNT_W'(dfgr_pkg::RFC2_CYC)
                  : dfgr_pkg::CNT_W'(dfgr_pkg::RFC1_CYC);     // see (RULE5)
               next_q.st = dfgr_pkg::DFGR_HOST_WAIT;
            end
         end
         dfgr_pkg::DFGR_HOST_WAIT:
         begin
            next_q.wait_c = q.wait_c - 1'b1;
            if (q.wait_c <= dfgr_pkg::CNT_W'(2))
               next_q.st = q.extra != 3'h0 ? dfgr_pkg::DFGR_HOST_EXTRA
                                           : dfgr_pkg::DFGR_HOST_IDLE;
         end
         dfgr_pkg::DFGR_HOST_SELF:
            if (req_sr_exit)
            begin
               next_q.srx = 1'b1;
               // Fixed modes forbid 1x, so a partial group gets 2 or 4 extras
               next_q.extra = (q.mode == dfgr_pkg::GRAN_FIXED_1X
                               || group_whole) ? 3'h0
                            : q.mode[2] ? 3'h1
                            : mode_quad ? 3'h4 : 3'h2;  // see (RULE17) (RULE18)
               next_q.grp = 2'h0;
               next_q.st = next_q.extra != 3'h0 ? dfgr_pkg::DFGR_HOST_EXTRA
                                                : dfgr_pkg::DFGR_HOST_IDLE;
            end
         dfgr_pkg::DFGR_HOST_EXTRA:
         begin
            // Extra refresh leaves the interval timer untouched
            next_q.ref_c = 1'b1;                              // see (RULE19)
            next_q.hi = !q.mode[2];                           // see (RULE6)
            next_q.extra = q.extra - 3'h1;
            next_q.wait_c = q.mode[2] ? dfgr_pkg::CNT_W'(dfgr_pkg::RFC1_CYC)
                          : mode_quad ? dfgr_pkg::CNT_W'(dfgr_pkg::RFC4_CYC)
                          : dfgr_pkg::CNT_W'(dfgr_pkg::RFC2_CYC);
            next_q.st = dfgr_pkg::DFGR_HOST_WAIT;
         end
         dfgr_pkg::DFGR_HOST_MODE:
         begin
            next_q.mrs = 1'b1;
            next_q.acc = 1'b1;
            next_q.mode = q.pend;
            next_q.grp = 2'h0;                                // see (RULE14)
            // New rate applies at once: refresh right after the write
            next_q.refi = '0;                                 // see (RULE9)
            next_q.wait_c = dfgr_pkg::CNT_W'(2);
            next_q.st = dfgr_pkg::DFGR_HOST_WAIT;
         end
         default:
            next_q.st = dfgr_pkg::DFGR_HOST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         q <= '0;
      else
         q <= next_q;
   end

   // Command pins decoded from registered strobes
   assign bus.cs_n     = !(q.ref_c || q.mrs);
   assign bus.act_n    = 1'b1;
   assign bus.ras_n    = !q.ref_c;
   assign bus.cas_n    = !q.ref_c;
   assign bus.we_n     = 1'b1;
   assign bus.bg0      = q.hi;
   assign bus.mrs_sel  = q.mrs;
   assign bus.addr     = {5'h00, q.mode, 6'h00};
   assign bus.sr_enter = q.sre;
   assign bus.sr_exit  = q.srx;
   assign mode_accepted = q.acc;
   assign mode_refused  = q.rfs;
   assign group_count   = q.grp;
   assign ctrl_idle     = (q.st == dfgr_pkg::DFGR_HOST_IDLE);
endmodule // dfgr_controller

/* hdl/dfgr_pkg.sv */
package dfgr_pkg;
   // Granularity field codes
   localparam logic [2:0] GRAN_FIXED_1X = 3'h0;
   localparam logic [2:0] GRAN_FIXED_2X = 3'h1;
   localparam logic [2:0] GRAN_FIXED_4X = 3'h2;
   localparam logic [2:0] GRAN_OTF_1X2X = 3'h5;
   localparam logic [2:0] GRAN_OTF_1X4X = 3'h6;
   localparam logic [2:0] GRAN_RESET    = 3'h0;
   // Field positions inside the MR3 address word
   localparam int GRAN_LSB = 6;
   localparam int GRAN_MSB = 8;
   // Timing figures
   localparam int CLK_PERIOD_PS   = 10000;
   localparam int REFI_BASE_NS    = 7800;
   localparam int RFC1_NS         = 350;
   localparam int RFC2_NS         = 260;
   localparam int RFC4_NS         = 160;
   localparam int REFI1_CYC = (REFI_BASE_NS * 1000) / CLK_PERIOD_PS;
   localparam int REFI2_CYC = REFI1_CYC / 2;
   localparam int REFI4_CYC = REFI1_CYC / 4;
   localparam int RFC1_CYC = (RFC1_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RFC2_CYC = (RFC2_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RFC4_CYC = (RFC4_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 16;
   // Refresh granularity of one command
   typedef enum logic [1:0]
   {
      DFGR_RATE_1X = 2'b00,
      DFGR_RATE_2X = 2'b01,
      DFGR_RATE_4X = 2'b10
   } dfgr_rate_e;
   // Device state machine
   typedef enum logic [1:0]
   {
      DFGR_DEV_IDLE   = 2'b00,
      DFGR_DEV_BUSY   = 2'b01,
      DFGR_DEV_SELF   = 2'b10
   } dfgr_dev_e;
   // Controller state machine
   typedef enum logic [2:0]
   {
      DFGR_HOST_IDLE  = 3'b000,
      DFGR_HOST_WAIT  = 3'b001,
      DFGR_HOST_SELF  = 3'b010,
      DFGR_HOST_EXTRA = 3'b011,
      DFGR_HOST_MODE  = 3'b100
   } dfgr_host_e;
endpackage

/* hdl/dfgr_if.sv */
`timescale 1ns/1ps
// Command/address path between controller and device
interface dfgr_if;
   logic        cs_n;
   logic        act_n;
   logic        ras_n;
   logic        cas_n;
   logic        we_n;
   logic        bg0;
   logic        mrs_sel;
   logic [13:0] addr;
   logic        sr_enter;
   logic        sr_exit;
   modport device
   (
      input cs_n, act_n, ras_n, cas_n, we_n, bg0, mrs_sel, addr,
      input sr_enter, sr_exit
   );
   modport controller
   (
      output cs_n, act_n, ras_n, cas_n, we_n, bg0, mrs_sel, addr,
      output sr_enter, sr_exit
   );
endinterface

/* hdl/dfgr_device.sv */
`timescale 1ns/1ps
// Overview of operation
// (RULE1) Refresh decode; BG0 picks rate in ON_THE_FLY_GRANULARITY
// (RULE2) Reset leaves fixed 1x, base interval
// (RULE3) 2x modes refresh at half interval
// (RULE4) 4x modes refresh at quarter interval
// (RULE5) Wait 350, 260 or 160 ns
// (RULE6) Fixed modes allow only own rate
// (RULE7) ON_THE_FLY_GRANULARITY 1x/2x runs both granularities
// (RULE8) ON_THE_FLY_GRANULARITY 1x/4x high rate is 4x
// (RULE9) New rate timing applies immediately
// (RULE10) Even 2x count before rate change
// (RULE11) Even 2x count between 1x refreshes
// (RULE12) Four-multiple 4x count before change
// (RULE13) Four-multiple 4x between 1x refreshes
// (RULE14) Fixed 1x free; same rate no change
// (RULE15) Temperature refresh needs fixed 1x
// (RULE16) Self refresh entry allowed any count
// (RULE17) Odd 2x count needs extra refresh
// (RULE18) Partial 4x group needs extra refresh
// (RULE19) Extra refreshes excluded from interval
// (RULE20) Field codes 000 001 010 101 110
// (RULE21) Enable ON_THE_FLY_GRANULARITY by MRS before use
// (RULE22) Controller keeps modulo-four refresh count; in 2x modes it counts modulo two
module dfgr_device
(
   input  wire logic          ref_clk,
   input  wire logic          arst_n,
   dfgr_if.device             bus,
   output logic [2:0]         refresh_granularity_mode,
   output logic               refresh_busy,
   output logic [1:0]         refresh_rate,
   output logic               refresh_done,
   output logic               self_refresh,
   output logic               reserved_code
);
   typedef struct packed {
      logic [2:0]                  mode;
      dfgr_pkg::dfgr_dev_e         st;
      dfgr_pkg::dfgr_rate_e        rate;
      logic [dfgr_pkg::CNT_W-1:0]  cnt;
      logic                        done;
      logic                        rsvd;
   } dfgr_dev_s;

   dfgr_dev_s q;
   dfgr_dev_s next_q;
   logic      is_ref;
   logic      is_mrs3;
   logic [2:0] code;

   // Refresh decode: CS low, ACT high, RAS low, CAS low, WE high
   assign is_ref = !bus.cs_n && bus.act_n && !bus.ras_n && !bus.cas_n
                   && bus.we_n && !bus.mrs_sel;                // see (RULE1)
   assign is_mrs3 = !bus.cs_n && bus.mrs_sel;
   assign code = bus.addr[dfgr_pkg::GRAN_MSB:dfgr_pkg::GRAN_LSB];

   // Next state: mode writes, refresh granularity and cycle timer
   always_comb
   begin
      next_q = q;
      next_q.done = 1'b0;
      if (is_mrs3 && q.st == dfgr_pkg::DFGR_DEV_IDLE)
      begin
         // Reserved codes are ignored so the mode stays valid
         unique case (code)                                   // see (RULE20)
            dfgr_pkg::GRAN_FIXED_1X, dfgr_pkg::GRAN_FIXED_2X,
            dfgr_pkg::GRAN_FIXED_4X, dfgr_pkg::GRAN_OTF_1X2X,
            dfgr_pkg::GRAN_OTF_1X4X:
            begin
               next_q.mode = code;                            // see (RULE9)
               next_q.rsvd = 1'b0;
            end
            default:
               next_q.rsvd = 1'b1;
         endcase
      end
      unique case (q.st)
         dfgr_pkg::DFGR_DEV_IDLE:
         begin
            if (bus.sr_enter)
               next_q.st = dfgr_pkg::DFGR_DEV_SELF;           // see (RULE16)
            else if (is_ref)
            begin
               // BG0 counts only when the mode's top bit marks ON_THE_FLY_GRANULARITY
               if (q.mode[2] && !bus.bg0)
                  next_q.rate = dfgr_pkg::DFGR_RATE_1X;       // see (RULE1)
               else if (q.mode == dfgr_pkg::GRAN_OTF_1X2X)
                  next_q.rate = dfgr_pkg::DFGR_RATE_2X;       // see (RULE7)
               else if (q.mode == dfgr_pkg::GRAN_OTF_1X4X)
                  next_q.rate = dfgr_pkg::DFGR_RATE_4X;       // see (RULE8)
               else if (q.mode == dfgr_pkg::GRAN_FIXED_2X)
                  next_q.rate = dfgr_pkg::DFGR_RATE_2X;
               else if (q.mode == dfgr_pkg::GRAN_FIXED_4X)
                  next_q.rate = dfgr_pkg::DFGR_RATE_4X;
               else
                  next_q.rate = dfgr_pkg::DFGR_RATE_1X;       // see (RULE2)
               next_q.st = dfgr_pkg::DFGR_DEV_BUSY;
               next_q.cnt = '0;
            end
         end
         dfgr_pkg::DFGR_DEV_BUSY:
         begin
            // Each command's own cycle time counts from its issue
            next_q.cnt = q.cnt + 1'b1;                        // see (RULE9)
            if ((q.rate == dfgr_pkg::DFGR_RATE_1X
                 && q.cnt == dfgr_pkg::CNT_W'(dfgr_pkg::RFC1_CYC - 2)) ||
                (q.rate == dfgr_pkg::DFGR_RATE_2X
                 && q.cnt == dfgr_pkg::CNT_W'(dfgr_pkg::RFC2_CYC - 2)) ||
                (q.rate == dfgr_pkg::DFGR_RATE_4X
                 && q.cnt == dfgr_pkg::CNT_W'(dfgr_pkg::RFC4_CYC - 2)))
            begin
               next_q.st = dfgr_pkg::DFGR_DEV_IDLE;           // see (RULE5)
               next_q.done = 1'b1;
            end
         end
         dfgr_pkg::DFGR_DEV_SELF:
            if (bus.sr_exit)
               next_q.st = dfgr_pkg::DFGR_DEV_IDLE;
         default:
            next_q.st = dfgr_pkg::DFGR_DEV_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         q.mode <= dfgr_pkg::GRAN_RESET;                      // see (RULE2)
         q.st   <= dfgr_pkg::DFGR_DEV_IDLE;
         q.rate <= dfgr_pkg::DFGR_RATE_1X;
         q.cnt  <= '0;
         q.done <= 1'b0;
         q.rsvd <= 1'b0;
      end
      else
         q <= next_q;
   end

   assign refresh_granularity_mode = q.mode;
   assign refresh_busy  = (q.st == dfgr_pkg::DFGR_DEV_BUSY);
   assign refresh_rate  = q.rate;
   assign refresh_done  = q.done;
   assign self_refresh  = (q.st == dfgr_pkg::DFGR_DEV_SELF);
   assign reserved_code = q.rsvd;
endmodule // dfgr_device

/* test/dfgr_assertions.sv */
`timescale 1ns/1ps
// Watches the command path that joins the two ends
module dfgr_assertions
#(
   parameter int REFI1_CYC = 780
)
(
   input wire logic        ref_clk,
   input wire logic        arst_n,
   input wire logic        cs_n,
   input wire logic        act_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic        bg0,
   input wire logic        mrs_sel,
   input wire logic [13:0] addr,
   input wire logic        sr_enter,
   input wire logic        sr_exit
);
   localparam int SLACK = dfgr_pkg::RFC1_CYC + 4;
   logic [2:0]  mode;
   logic [15:0] gap;
   logic [5:0]  rfc;
   logic [1:0]  grp;
   logic        in_sr;
   logic        part;
   logic        ref_c;
   logic        mrs_c;
   logic        hi;
   logic        two;
   logic        four;
   logic [15:0] refi;
   // Decode of the command now on the wire against the tracked mode
   assign ref_c = !cs_n && !mrs_sel;
   assign mrs_c = !cs_n && mrs_sel;
   assign two   = mode == 3'h1 || mode == 3'h5;
   assign four  = mode == 3'h2 || mode == 3'h6;
   assign hi    = mode[2] ? bg0 : two || four;
   assign refi  = 16'(mode == 3'h1 ? REFI1_CYC / 2 :
                      mode == 3'h2 ? REFI1_CYC / 4 : REFI1_CYC);
   // Mode follows legal codes only, as the device ignores reserved ones
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mode  <= 3'h0;
         gap   <= 16'h0;
         rfc   <= 6'h0;
         grp   <= 2'h0;
         in_sr <= 1'b0;
         part  <= 1'b0;
      end
      else
      begin
         gap <= (!cs_n || sr_exit || in_sr) ? 16'h0 : gap + 16'h1;
         if (mrs_c && (addr[8:6] inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6}))
            mode <= addr[8:6];
         if (!cs_n)
            rfc <= mrs_c ? 6'h0 : !hi ? 6'(dfgr_pkg::RFC1_CYC) :
                   two ? 6'(dfgr_pkg::RFC2_CYC) : 6'(dfgr_pkg::RFC4_CYC);
         else if (sr_exit)
            rfc <= 6'h0;
         if (mrs_c || sr_exit || (ref_c && !hi))
            grp <= 2'h0;
         else if (ref_c)
            grp <= grp + 2'h1;
         if (sr_enter)
            part <= two ? grp[0] : four && grp != 2'h0;
         in_sr <= sr_enter || (in_sr && !sr_exit);
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);
   chk_ref_code:
   assert property (ref_c |-> act_n && !ras_n && !cas_n && we_n)
      else $error("refresh encoding wrong");
   chk_rfc_gap:
   assert property (!cs_n |-> gap + 16'h1 >= 16'(rfc))
      else $error("command inside refresh cycle time");
   chk_refi_bound:
   assert property (!in_sr |-> gap <= refi + 16'(SLACK))
      else $error("refresh interval overrun");
   chk_mrs_group:
   assert property (mrs_c |-> (two ? !grp[0] : four ? grp == 2'h0 : 1'b1))
      else $error("rate change with partial group");
   chk_onex_group:
   assert property (ref_c && !hi && mode[2] |->
                    (two ? !grp[0] : grp == 2'h0))
      else $error("single rate refresh splits a group");
   chk_sr_quiet:
   assert property (in_sr |-> cs_n)
      else $error("command during self refresh");
   chk_sr_pair:
   assert property (sr_exit |-> in_sr && !sr_enter)
      else $error("self refresh exit without entry");
   chk_sr_extra:
   assert property (sr_exit && part |-> ##[1:60] ref_c)
      else $error("no extra refresh after exit");
   cov_otf_quad: cover property (mrs_c && addr[8:6] == 3'h6);
   cov_quad_ref: cover property (ref_c && hi && four);
   cov_sr_part: cover property (sr_exit && part);
endmodule // dfgr_assertions

/* test/tb.sv */
`timescale 1ns/1ps
// Joins both ends and checks refresh behaviour seen at the wire
module tb;
   logic       ref_clk;
   logic       arst_n;
   logic [2:0] req_mode;
   logic       req_mode_valid;
   logic       req_high_rate;
   logic       temp_refresh;
   logic       req_sr_enter;
   logic       req_sr_exit;
   logic [2:0] dev_mode;
   logic       busy;
   logic [1:0] rate;
   logic       rf_done;
   logic       in_self;
   logic       rsv;
   logic       mode_acc;
   logic       mode_rfs;
   logic [1:0] grp;
   logic [2:0] exp_mode;
   logic [2:0] cur_mode;
   logic [1:0] exp_rate;
   int         error_cnt;
   int         checked;
   int         seed;
   int         cyc;
   int         t_cmd;
   int         n_done;
   logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h0};
   dfgr_if bus ();
   dfgr_device i_dfgr_device
   (
      .ref_clk                  (ref_clk),
      .arst_n                   (arst_n),
      .bus                      (bus),
      .refresh_granularity_mode (dev_mode),
      .refresh_busy             (busy),
      .refresh_rate             (rate),
      .refresh_done             (rf_done),
      .self_refresh             (in_self),
      .reserved_code            (rsv)
   );
   // Short interval keeps the run brief; 4x interval still exceeds its tRFC
   dfgr_controller #(.REFI1_CYC(160)) i_dfgr_controller
   (
      .ref_clk                        (ref_clk),
      .arst_n                         (arst_n),
      .bus                            (bus),
      .req_mode                       (req_mode),
      .req_mode_valid                 (req_mode_valid),
      .req_high_rate                  (req_high_rate),
      .temperature_controlled_refresh (temp_refresh),
      .req_sr_enter                   (req_sr_enter),
      .req_sr_exit                    (req_sr_exit),
      .mode_accepted                  (mode_acc),
      .mode_refused                   (mode_rfs),
      .group_count                    (grp),
      .ctrl_idle                      ()
   );
   dfgr_assertions #(.REFI1_CYC(160)) i_dfgr_assertions
   (
      .ref_clk  (ref_clk),
      .arst_n   (arst_n),
      .cs_n     (bus.cs_n),
      .act_n    (bus.act_n),
      .ras_n    (bus.ras_n),
      .cas_n    (bus.cas_n),
      .we_n     (bus.we_n),
      .bg0      (bus.bg0),
      .mrs_sel  (bus.mrs_sel),
      .addr     (bus.addr),
      .sr_enter (bus.sr_enter),
      .sr_exit  (bus.sr_exit)
   );
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   function automatic int rfc_of(input logic [1:0] r);
      int ns;
      ns = r == 2'h0 ? dfgr_pkg::RFC1_NS :
           r == 2'h1 ? dfgr_pkg::RFC2_NS : dfgr_pkg::RFC4_NS;
      return (ns * 1000 + dfgr_pkg::CLK_PERIOD_PS - 1) /
             dfgr_pkg::CLK_PERIOD_PS;
   endfunction
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wrap_up();
      $display("mismatches %0d, checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Wire monitor: predicts rate and length of every refresh
   always @(posedge ref_clk)
   begin
      cyc++;
      if (rf_done === 1'b1)
      begin
         n_done++;
         cmp(16'(rate), 16'(exp_rate), "refresh rate");
         cmp(16'(cyc - t_cmd), 16'(rfc_of(exp_rate)), "refresh length");
         cmp(16'(busy), 16'h0, "busy cleared");
      end
      if (arst_n && cyc == t_cmd + 1)
         cmp(16'(busy), 16'h1, "busy after refresh");
      if (arst_n && !bus.cs_n && bus.mrs_sel)
      begin
         cmp(16'(bus.addr[8:6]), 16'(exp_mode), "code on wire");
         // Reserved codes leave the device mode as it was
         if (exp_mode inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6})
            cur_mode = exp_mode;
      end
      if (arst_n && !bus.cs_n && !bus.mrs_sel)
      begin
         t_cmd = cyc;
         exp_rate = cur_mode == 3'h1 ? 2'h1 : cur_mode == 3'h2 ? 2'h2 :
                    !cur_mode[2] || !bus.bg0 ? 2'h0 :
                    cur_mode == 3'h5 ? 2'h1 : 2'h2;
      end
   end
   // Fresh random rate choice after each command
   always @(posedge ref_clk)
      if (!bus.cs_n)
         req_high_rate <= #1 1'($random(seed));
   task automatic wait_done(input int k);
      int n;
      int t;
      t = n_done + k;
      n = 0;
      while (n_done < t && n < 20000)
      begin
         tick(1);
         n++;
      end
      cmp(16'(n_done >= t), 16'h1, "refreshes keep coming");
   endtask
   task automatic set_mode(input logic [2:0] c, input logic ok);
      int n;
      exp_mode = c;
      req_mode = c;
      req_mode_valid = 1'b1;
      n = 0;
      while (mode_acc !== 1'b1 && n < 4000)
      begin
         tick(1);
         n++;
      end
      cmp(16'(n < 4000), 16'(ok), "mode acceptance");
      cmp(16'(mode_rfs), 16'(!ok), "refusal flag");
      if (ok)
         cmp(16'(grp), 16'h0, "group count cleared");
      req_mode_valid = 1'b0;
      tick(2);
      cmp(16'(dev_mode), 16'(cur_mode), "mode held by device");
   endtask
   task automatic self_ref();
      int n;
      req_sr_enter = 1'b1;
      n = 0;
      while (in_self !== 1'b1 && n < 4000)
      begin
         tick(1);
         n++;
      end
      req_sr_enter = 1'b0;
      cmp(16'(in_self), 16'h1, "self refresh entry");
      tick(30);
      req_sr_exit = 1'b1;
      n = 0;
      while (in_self !== 1'b0 && n < 4000)
      begin
         tick(1);
         n++;
      end
      req_sr_exit = 1'b0;
      cmp(16'(in_self), 16'h0, "self refresh exit");
      wait_done(2);
   endtask
   initial
   begin
      #800000;
      error_cnt++;
      $display("wrong value at %0t: run timed out", $time);
      wrap_up();
   end
   initial
   begin
      seed = 32'he098b0d2;
      arst_n = 1'b0;
      req_mode = 3'h0;
      req_mode_valid = 1'b0;
      req_high_rate = 1'b0;
      temp_refresh = 1'b0;
      req_sr_enter = 1'b0;
      req_sr_exit = 1'b0;
      exp_mode = 3'h0;
      cur_mode = 3'h0;
      exp_rate = 2'h0;
      tick(6);
      arst_n = 1'b1;
      cmp(16'(dev_mode), 16'(dfgr_pkg::GRAN_RESET), "mode at reset");
      cmp(16'(bus.cs_n), 16'h1, "bus idle at reset");
      wait_done(3);
      // Every legal code, a random run of refreshes, then self refresh
      foreach (codes[i])
      begin
         set_mode(codes[i], 1'b1);
         wait_done(5 + ($random(seed) & 3));
         self_ref();
      end
      temp_refresh = 1'b1;
      set_mode(3'h5, 1'b0);
      temp_refresh = 1'b0;
      set_mode(3'h5, 1'b1);
      wait_done(4);
      // Reserved code: flagged, and the old mode stays in force
      set_mode(3'h3, 1'b1);
      cmp(16'(rsv), 16'h1, "reserved code flagged");
      wait_done(2);
      wrap_up();
   end
endmodule // tb
